// *** pmo_top.sv ***
/*
  pmo_top: data pin logic of a pulse-density microphone output.
  assumes the host makes the bit clock; it, the strap and the converter
  bit are sampled through two flip-flops on the 100 MHz clock.
*/
`timescale 1ns/1ps
module pmo_top (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic BIT_CLK,
  input wire logic EDGE_SEL,
  input wire logic PDM_BIT,
  output logic DATA_O,
  output logic DATA_OE,
  output logic AWAKE
);
  logic [1:0] bclk_s;
  logic [1:0] sel_s;
  logic [1:0] bit_s;
  logic bclk_d;
  logic rise;
  logic fall;
  logic drive_edge;
  logic release_edge;
  logic [15:0] period_r;
  logic [4:0] fast_r;
  logic fast_edge;
  pmo_pkg::pmo_state_t state_r;
  logic [3:0] dly_r;
  logic pend_drive_r;
  logic hold_bit_r;
  logic fifo_valid;
  logic fifo_take;
  logic fifo_bit;
  pmo_stream_if bits ();

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      bclk_s <= 2'h0;
      sel_s <= 2'h0;
      bit_s <= 2'h0;
      bclk_d <= 1'b0;
    end else begin
      bclk_s <= {bclk_s[0], BIT_CLK};
      sel_s <= {sel_s[0], EDGE_SEL};
      bit_s <= {bit_s[0], PDM_BIT};
      bclk_d <= bclk_s[1];
    end
  end

  assign rise = bclk_s[1] && !bclk_d;
  assign fall = !bclk_s[1] && bclk_d;
  assign drive_edge = sel_s[1] ? rise : fall;
  assign release_edge = sel_s[1] ? fall : rise;

  // measure the bit clock period between rising edges
  assign fast_edge = rise &&
    (period_r < 16'(pmo_pkg::WAKE_PERIOD_CYC));
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      period_r <= pmo_pkg::PERIOD_RST;
    end else if (rise) begin
      period_r <= 16'h0000;
    end else if (period_r != 16'hffff) begin
      period_r <= period_r + 16'h0001;
    end
  end

  // power state with hysteresis between the two thresholds
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      state_r <= pmo_pkg::PMO_SLEEP;
      fast_r <= 5'h00;
    end else begin
      if (period_r >= 16'(pmo_pkg::SLEEP_PERIOD_CYC)) begin
        state_r <= pmo_pkg::PMO_SLEEP;
        fast_r <= 5'h00;
      end else begin
        case (state_r)
          pmo_pkg::PMO_SLEEP: begin
            if (fast_edge) begin
              state_r <= pmo_pkg::PMO_WAKING;
              fast_r <= 5'h01;
            end
          end
          pmo_pkg::PMO_WAKING: begin
            if (rise) begin
              if (!fast_edge) begin
                state_r <= pmo_pkg::PMO_SLEEP;
                fast_r <= 5'h00;
              end else if (fast_r == 5'(pmo_pkg::WAKE_PERIODS - 1)) begin
                state_r <= pmo_pkg::PMO_ACTIVE;
              end else begin
                fast_r <= fast_r + 5'h01;
              end
            end
          end
          pmo_pkg::PMO_ACTIVE: begin
            state_r <= pmo_pkg::PMO_ACTIVE;
          end
          default: begin
            state_r <= pmo_pkg::PMO_SLEEP;
          end
        endcase
      end
    end
  end

  // converter bits are captured once per bit clock period
  assign bits.valid = drive_edge && state_r == pmo_pkg::PMO_ACTIVE;
  assign bits.data = bit_s[1];

  pmo_fifo #(
    .WIDTH(1),
    .DEPTH(pmo_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(CLOCK),
    .rst_n(RESETN && state_r == pmo_pkg::PMO_ACTIVE),
    .in_valid(bits.valid),
    .in_ready(bits.ready),
    .in_data(bits.data),
    .out_valid(fifo_valid),
    .out_ready(fifo_take),
    .out_data(fifo_bit)
  );
  // pop only in the cycle that really puts the bit on the line
  assign fifo_take = pend_drive_r && dly_r == 4'h0 && fifo_valid &&
    !release_edge && !drive_edge && state_r == pmo_pkg::PMO_ACTIVE;

  // drive after drive_delay, release on the clock right after the release edge
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      dly_r <= 4'h0;
      pend_drive_r <= 1'b0;
      hold_bit_r <= 1'b0;
      DATA_O <= 1'b0;
      DATA_OE <= 1'b0;
      AWAKE <= 1'b0;
    end else begin
      AWAKE <= state_r == pmo_pkg::PMO_ACTIVE;
      if (state_r != pmo_pkg::PMO_ACTIVE) begin
        DATA_OE <= 1'b0;
        pend_drive_r <= 1'b0;
        dly_r <= 4'h0;
      end else if (release_edge) begin
        DATA_OE <= 1'b0;
        pend_drive_r <= 1'b0;
      end else if (drive_edge) begin
        pend_drive_r <= 1'b1;
        dly_r <= 4'(pmo_pkg::DRIVE_DELAY_CYC - 1);
      end else if (pend_drive_r) begin
        if (dly_r != 4'h0) begin
          dly_r <= dly_r - 4'h1;
        end else begin
          pend_drive_r <= 1'b0;
          DATA_OE <= 1'b1;
          DATA_O <= fifo_valid ? fifo_bit : hold_bit_r;
          if (fifo_valid) begin
            hold_bit_r <= fifo_bit;
          end
        end
      end
    end
  end

  property p_release;
    @(posedge CLOCK) disable iff (!RESETN)
      release_edge |=> !DATA_OE;
  endproperty
  a_release: assert property (p_release)
    else $error("line not released after release edge");

  property p_sleep_float;
    @(posedge CLOCK) disable iff (!RESETN)
      !AWAKE |-> !DATA_OE || $past(state_r) == pmo_pkg::PMO_ACTIVE;
  endproperty
  a_sleep_float: assert property (p_sleep_float)
    else $error("line driven while asleep");

  sequence s_drive_ev;
    drive_edge && state_r == pmo_pkg::PMO_ACTIVE;
  endsequence
  property p_drive;
    @(posedge CLOCK) disable iff (!RESETN)
      s_drive_ev ##1 !release_edge [*2] |=> DATA_OE;
  endproperty
  a_drive: assert property (p_drive)
    else $error("line not driven after drive edge");

  property p_stop_sleep;
    @(posedge CLOCK) disable iff (!RESETN)
      period_r >= 16'(pmo_pkg::SLEEP_PERIOD_CYC) |-> ##2 !AWAKE;
  endproperty
  a_stop_sleep: assert property (p_stop_sleep)
    else $error("not asleep after slow clock");

  // the line is only taken after a drive edge and its delay
  property p_oe_after_drive;
    @(posedge CLOCK) disable iff (!RESETN)
      $rose(DATA_OE) |-> $past(drive_edge, 3);
  endproperty
  a_oe_after_drive: assert property (p_oe_after_drive)
    else $error("line driven without a preceding drive edge");

  // waking up needs a fast bit clock period just before
  property p_wake_fast;
    @(posedge CLOCK) disable iff (!RESETN)
      $rose(AWAKE) |-> $past(fast_edge, 2);
  endproperty
  a_wake_fast: assert property (p_wake_fast)
    else $error("woke without a fast bit clock");
endmodule // pmo_top

// *** pmo_pkg.sv ***
/*
  pmo_pkg: constants for the pulse-density microphone output block.
  assumes a 100 MHz system clock; all times derived from it.
*/
package pmo_pkg;
  localparam int unsigned CLK_MHZ = 100;
  // bit clock rate thresholds, in kHz
  localparam int unsigned WAKE_KHZ = 300;
  localparam int unsigned SLEEP_KHZ = 70;
  // wake_latency and sleep_latency limits, in microseconds
  localparam int unsigned WAKE_LAT_MAX_US = 2000;
  localparam int unsigned SLEEP_LAT_MAX_US = 1000;
  // drive_delay minimum 18 ns, release_delay maximum 16 ns; pmo_top releases about 20 to 30 ns after the bit clock edge
  localparam int unsigned DRIVE_DELAY_NS = 18;
  localparam int unsigned RELEASE_DELAY_NS = 16;
  // longest bit-clock period still counted as fast: 1/300 kHz, rounded down
  localparam int unsigned WAKE_PERIOD_CYC = (CLK_MHZ * 1000) / WAKE_KHZ;
  // shortest period counted as slow: 1/70 kHz, rounded up
  localparam int unsigned SLEEP_PERIOD_CYC =
    (CLK_MHZ * 1000 + SLEEP_KHZ - 1) / SLEEP_KHZ;
  // drive_delay rounds up, release_delay rounds down (at least one cycle)
  localparam int unsigned DRIVE_DELAY_CYC =
    (DRIVE_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RELEASE_DELAY_CYC =
    (RELEASE_DELAY_NS * CLK_MHZ / 1000 < 1) ? 1 :
    RELEASE_DELAY_NS * CLK_MHZ / 1000;
  // consecutive fast periods needed to wake, kept well inside wake_latency
  localparam int unsigned WAKE_PERIODS = 16;
  localparam int unsigned WAKE_LAT_CYC = WAKE_LAT_MAX_US * CLK_MHZ;
  localparam int unsigned SLEEP_LAT_CYC = SLEEP_LAT_MAX_US * CLK_MHZ;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam logic [15:0] PERIOD_RST = 16'h0000;
  typedef enum logic [1:0] {
    PMO_SLEEP = 2'b00,
    PMO_WAKING = 2'b01,
    PMO_ACTIVE = 2'b10
  } pmo_state_t;
endpackage

// *** pmo_stream_if.sv ***
/*
  pmo_stream_if: valid/ready bit stream between the top and its fifo.
  assumes a single clock shared by both ends.
*/
`timescale 1ns/1ps
interface pmo_stream_if;
  logic valid;
  logic ready;
  logic data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface // pmo_stream_if

// *** pmo_fifo.sv ***
/*
  pmo_fifo: synchronous fifo with valid/ready on both sides.
  assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module pmo_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  // full only when the count reaches the whole depth
  assign in_ready = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data = mem[rd_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // pmo_fifo

// *** pmo_host_model.sv ***
/*
  pmo_host_model: host side of the pdm link, makes the bit clock and
  resolves the shared data wire. assumes the device drives through oe.
*/
`timescale 1ns/1ps
module pmo_host_model (
  input wire logic en,
  input int half_ps,
  input wire logic data_o,
  input wire logic data_oe,
  output logic bit_clk,
  output logic line
);
  logic last_r = 1'b0;
  initial bit_clk = 1'b0;
  // equal halves, clock parked low while stopped
  always begin
    if (en) begin
      #(half_ps / 1000.0) bit_clk = ~bit_clk;
    end else begin
      bit_clk = 1'b0;
      @(en);
    end
  end
  // a floating wire shows the inverse of the last driven value
  always @(data_o or data_oe) begin
    if (data_oe) begin
      last_r = data_o;
    end
  end
  assign line = data_oe ? data_o : ~last_r;
endmodule // pmo_host_model

// *** tb_pmo_top.sv ***
/*
  tb_pmo_top: self-checking bench for pmo_top with a host model.
  assumes a 100 MHz CLOCK and a 125 ns bit clock, or a 10 us bit clock in the between-threshold runs.
*/
`timescale 1ns/1ps
module tb_pmo_top;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic edge_sel = 1'b0;
  logic pdm_bit = 1'b0;
  logic en = 1'b0;
  int half_ps = 62500;
  logic bclk, line, data_o, data_oe, awake;
  int num_errors = 0;
  int checks = 0;
  // rows: strap, converter bit, expected wire value
  logic [2:0] rows [4] = '{3'b000, 3'b011, 3'b100, 3'b111};
  always #5 clock = ~clock;
  pmo_top u_pmo_top (.CLOCK(clock), .RESETN(resetn), .BIT_CLK(bclk),
    .EDGE_SEL(edge_sel), .PDM_BIT(pdm_bit), .DATA_O(data_o),
    .DATA_OE(data_oe), .AWAKE(awake));
  pmo_host_model u_pmo_host_model (.en(en), .half_ps(half_ps),
    .data_o(data_o), .data_oe(data_oe), .bit_clk(bclk), .line(line));
  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic wait_awake(input logic lvl, input int lim);
    int n;
    n = 0;
    while (awake !== lvl && n < lim) begin
      @(negedge clock);
      n++;
    end
    check(lvl, awake);
    if (awake !== lvl) begin
      finish_test();
    end
  endtask
  task automatic go_edge(input logic drive);
    logic want;
    logic prev;
    int n;
    want = drive ~^ edge_sel;
    prev = bclk;
    n = 0;
    while (!(bclk === want && prev !== want) && n < 400) begin
      prev = bclk;
      #1;
      n++;
    end
    if (n >= 400) begin
      num_errors++;
      finish_test();
    end
  endtask
  task automatic run_clk(input logic on, input int hp, input int cyc);
    @(negedge clock);
    en = on;
    half_ps = hp;
    repeat (cyc) @(negedge clock);
  endtask
  initial begin
    repeat (20) @(negedge clock);
    resetn = 1'b1;
    check(1'b0, awake);
    check(1'b0, data_oe);
    for (int i = 0; i < 4; i++) begin
      @(negedge clock);
      edge_sel = rows[i][2];
      pdm_bit = rows[i][1];
      run_clk(1'b1, 62500, 1);
      wait_awake(1'b1, pmo_pkg::WAKE_LAT_CYC);
      repeat (400) @(negedge clock);
      repeat (8) begin
        go_edge(1'b1);
        #60;
        check(1'b1, data_oe);
        check(rows[i][0], line);
        go_edge(1'b0);
        #60;
        check(1'b0, data_oe);
      end
      run_clk(1'b0, 62500, 1);
      wait_awake(1'b0, pmo_pkg::SLEEP_LAT_CYC);
      check(1'b0, data_oe);
    end
    // between thresholds the state holds, awake and asleep alike
    run_clk(1'b1, 62500, 1);
    wait_awake(1'b1, pmo_pkg::WAKE_LAT_CYC);
    run_clk(1'b1, 5000000, 3000);
    check(1'b1, awake);
    // reset in mid-run with the slow clock still running
    @(negedge clock);
    resetn = 1'b0;
    repeat (4) @(negedge clock);
    check(1'b0, awake);
    check(1'b0, data_oe);
    check(1'b0, data_o);
    resetn = 1'b1;
    repeat (3000) @(negedge clock);
    check(1'b0, awake);
    run_clk(1'b0, 62500, 1);
    wait_awake(1'b0, pmo_pkg::SLEEP_LAT_CYC);
    run_clk(1'b1, 5000000, 3000);
    check(1'b0, awake);
    check(1'b0, data_oe);
    finish_test();
  end
endmodule // tb_pmo_top
